//--- core/serial_baud_rate_generator.sv
// Operation
// - divider is 8-bit after reset, 16-bit when wide_divider_select set
// - one divider times both asynchronous and synchronous operation
// - divider runs freely, period from high and low divisor bytes
// - async multiplier chosen by high_speed_select and wide_divider_select
// - synchronous mode ignores high_speed_select
// - writing either divisor byte clears the divider at once
// - rates: 8-bit slow async 64(n+1), 16-bit slow async 16(n+1), 16-bit fast async and sync 4(n+1)
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`include "baud_regs.svh"

module serial_baud_rate_generator
    import baud_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire axil_req_t axil_req,
    output axil_rsp_t      axil_rsp,
    input  wire logic      receiver_idle_flag,
    input  wire logic      autobaud_overflow_flag,
    output logic           baud_tick,
    output logic           sync_mode,
    output logic           clock_polarity_select,
    output logic           wakeup_enable,
    output logic           autobaud_enable
);

    if (ADDR_W != 8) begin : g_check
        $error("serial_baud_rate_generator: ADDR_W must be 8");
    end

    // ================================================================
    // address decode, shared by write and read paths
    function automatic reg_sel_t decode(input logic [7:0] addr);
        if (addr == `OFS_BAUD_CONTROL) begin
            return SEL_CONTROL;
        end else if (addr == `OFS_DIVISOR_LOW) begin
            return SEL_DIV_LOW;
        end else if (addr == `OFS_DIVISOR_HIGH) begin
            return SEL_DIV_HIGH;
        end else if (addr == `OFS_MODE_CONTROL) begin
            return SEL_MODE;
        end else if (addr == `OFS_TIMER_COUNT) begin
            return SEL_COUNT;
        end else begin
            return SEL_NONE;
        end
    endfunction : decode

    // ================================================================
    // prescaler length: the per-bit multiplier minus one
    function automatic logic [5:0] presc_last(input logic sync,
                                              input logic high,
                                              input logic wide);
        if (sync) begin
            return `PRESC_LAST_4;
        end else if (!wide && !high) begin
            return `PRESC_LAST_64;
        end else if (wide && high) begin
            return `PRESC_LAST_4;
        end else begin
            return `PRESC_LAST_16;
        end
    endfunction : presc_last

    // ================================================================
    // register and bus state
    logic [7:0]  control_r, control_nxt;
    logic [7:0]  div_low_r, div_low_nxt;
    logic [7:0]  div_high_r, div_high_nxt;
    logic [7:0]  mode_r, mode_nxt;
    logic        aw_held_r, aw_held_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic        w_held_r, w_held_nxt;
    logic [7:0]  w_data_r, w_data_nxt;
    logic        w_lane_r, w_lane_nxt;
    axil_rsp_t   rsp_r, rsp_nxt;
    logic        div_write;

    // timer state
    logic [5:0]  presc_r, presc_nxt;
    logic [15:0] count_r, count_nxt;
    logic        tick_r, tick_nxt;
    logic [15:0] divisor;
    logic [5:0]  last_presc;

    assign divisor    = control_r[`BC_WIDE_DIVIDER] ?
                        {div_high_r, div_low_r} :
                        {8'h00, div_low_r};
    assign last_presc = presc_last(mode_r[`MC_SYNC_SELECT],
                                   mode_r[`MC_HIGH_SPEED],
                                   control_r[`BC_WIDE_DIVIDER]);

    // ================================================================
    // axi4-lite slave
    always_comb begin
        reg_sel_t wsel;
        reg_sel_t rsel;
        wsel         = decode(aw_addr_r);
        rsel         = decode(axil_req.araddr);
        control_nxt  = control_r;
        div_low_nxt  = div_low_r;
        div_high_nxt = div_high_r;
        mode_nxt     = mode_r;
        aw_held_nxt  = aw_held_r;
        aw_addr_nxt  = aw_addr_r;
        w_held_nxt   = w_held_r;
        w_data_nxt   = w_data_r;
        w_lane_nxt   = w_lane_r;
        rsp_nxt      = rsp_r;
        div_write    = 1'b0;

        if (axil_req.awvalid && rsp_r.awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = axil_req.awaddr;
        end
        if (axil_req.wvalid && rsp_r.wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = axil_req.wdata[7:0];
            w_lane_nxt = axil_req.wstrb[0];
        end
        if (rsp_r.bvalid && axil_req.bready) begin
            rsp_nxt.bvalid = 1'b0;
        end

        // address and data may arrive in either order
        if (aw_held_r && w_held_r && !rsp_r.bvalid) begin
            aw_held_nxt    = 1'b0;
            w_held_nxt     = 1'b0;
            rsp_nxt.bvalid = 1'b1;
            rsp_nxt.bresp  = `RESP_OKAY;
            if (wsel == SEL_NONE) begin
                rsp_nxt.bresp = `RESP_SLVERR;
            end else if (w_lane_r) begin
                if (wsel == SEL_CONTROL) begin
                    control_nxt = w_data_r & `BC_RW_MASK;
                end else if (wsel == SEL_DIV_LOW) begin
                    div_low_nxt = w_data_r;
                    div_write   = 1'b1;
                end else if (wsel == SEL_DIV_HIGH) begin
                    div_high_nxt = w_data_r;
                    div_write    = 1'b1;
                end else if (wsel == SEL_MODE) begin
                    mode_nxt = w_data_r & `MC_RW_MASK;
                end
            end
        end
        rsp_nxt.awready = !aw_held_nxt && !rsp_nxt.bvalid;
        rsp_nxt.wready  = !w_held_nxt && !rsp_nxt.bvalid;

        if (rsp_r.rvalid && axil_req.rready) begin
            rsp_nxt.rvalid = 1'b0;
        end
        if (axil_req.arvalid && rsp_r.arready) begin
            rsp_nxt.rvalid = 1'b1;
            rsp_nxt.rresp  = `RESP_OKAY;
            rsp_nxt.rdata  = 32'h0000_0000;
            if (rsp_nxt.rvalid && rsel == SEL_CONTROL) begin
                rsp_nxt.rdata[7:0] = control_r;
                rsp_nxt.rdata[`BC_AUTOBAUD_OVF] = autobaud_overflow_flag;
                // software polls this before a clock change
                rsp_nxt.rdata[`BC_RX_IDLE] = receiver_idle_flag;
            end else if (rsel == SEL_DIV_LOW) begin
                rsp_nxt.rdata[7:0] = div_low_r;
            end else if (rsel == SEL_DIV_HIGH) begin
                rsp_nxt.rdata[7:0] = div_high_r;
            end else if (rsel == SEL_MODE) begin
                rsp_nxt.rdata[7:0] = mode_r;
            end else if (rsel == SEL_COUNT) begin
                rsp_nxt.rdata[15:0] = count_r;
            end else begin
                rsp_nxt.rresp = `RESP_SLVERR;
            end
        end
        rsp_nxt.arready = !rsp_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_r  <= `RST_BAUD_CONTROL;
            div_low_r  <= `RST_DIVISOR;
            div_high_r <= `RST_DIVISOR;
            mode_r     <= `RST_MODE_CONTROL;
            aw_held_r  <= 1'b0;
            aw_addr_r  <= 8'h00;
            w_held_r   <= 1'b0;
            w_data_r   <= 8'h00;
            w_lane_r   <= 1'b0;
            rsp_r      <= '0;
        end else begin
            control_r  <= control_nxt;
            div_low_r  <= div_low_nxt;
            div_high_r <= div_high_nxt;
            mode_r     <= mode_nxt;
            aw_held_r  <= aw_held_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_held_r   <= w_held_nxt;
            w_data_r   <= w_data_nxt;
            w_lane_r   <= w_lane_nxt;
            rsp_r      <= rsp_nxt;
        end
    end

    // ================================================================
    // divider timer: prescaler sets the multiplier, count sets n+1
    // mode bit changes take effect at once, mid-period, through last_presc
    always_comb begin
        presc_nxt = presc_r + 6'h01;
        count_nxt = count_r;
        tick_nxt  = 1'b0;
        if (div_write) begin
            presc_nxt = 6'h00;
            count_nxt = 16'h0000;
        end else if (presc_r >= last_presc) begin
            presc_nxt = 6'h00;
            if (count_r >= divisor) begin
                count_nxt = 16'h0000;
                tick_nxt  = 1'b1;
            end else begin
                count_nxt = count_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_r <= 6'h00;
            count_r <= 16'h0000;
            tick_r  <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign axil_rsp              = rsp_r;
    assign baud_tick             = tick_r;
    assign sync_mode             = mode_r[`MC_SYNC_SELECT];
    assign clock_polarity_select = control_r[`BC_CLK_POLARITY];
    assign wakeup_enable         = control_r[`BC_WAKEUP_EN];
    assign autobaud_enable       = control_r[`BC_AUTOBAUD_EN];

endmodule : serial_baud_rate_generator

//--- dv/baud_assertions.sv
// ==========================================================
// protocol and tick checks on the top-level ports
module baud_assertions
    import baud_pkg::*;
(
    input wire logic      aclk,
    input wire logic      aresetn,
    input wire axil_req_t axil_req,
    input wire axil_rsp_t axil_rsp,
    input wire logic      baud_tick
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // shortest bit period is four clocks, so ticks never bunch
    a_tick_gap: assert property (
        baud_tick |=> !baud_tick [*3]) else $error("ticks too close");
    a_rd_latency: assert property (
        axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("read answer late");
    a_wr_latency: assert property (axil_req.awvalid && axil_rsp.awready
        && axil_req.wvalid && axil_rsp.wready |-> ##2 axil_rsp.bvalid)
        else $error("write answer late");
    a_b_done: assert property (
        axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
        else $error("bvalid held after taken");
    a_r_done: assert property (
        axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
        else $error("rvalid held after taken");
    a_ar_block: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
        else $error("arready while read pending");
    a_aw_block: assert property (
        axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
        else $error("write ready while response pending");
    a_err_zero: assert property (
        axil_rsp.rvalid && axil_rsp.rresp == 2'h2 |-> axil_rsp.rdata == 0)
        else $error("error read returned data");
endmodule : baud_assertions

bind serial_baud_rate_generator baud_assertions u_chk (
    .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .baud_tick(baud_tick));

//--- dv/tb_serial_baud_rate_generator.sv
module tb_serial_baud_rate_generator
    import baud_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk;
    logic        aresetn;
    logic        idle_in;
    logic        ovf_in;
    logic        tick;
    logic        sync_o;
    wire [2:0]   lvl_o;
    logic        bv_q;
    axil_req_t   req;
    axil_rsp_t   rsp;
    int          failures;
    int          total_checks;
    int          cyc;
    int          seed = 88401;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          tq[$];

    serial_baud_rate_generator u_dut (.aclk(aclk), .aresetn(aresetn),
        .axil_req(req), .axil_rsp(rsp), .receiver_idle_flag(idle_in),
        .autobaud_overflow_flag(ovf_in), .baud_tick(tick),
        .sync_mode(sync_o), .clock_polarity_select(lvl_o[2]),
        .wakeup_enable(lvl_o[1]), .autobaud_enable(lvl_o[0]));

    task automatic err(input string m);
        failures++;
        $display("ERROR %0t %s", $time, m);
    endtask : err

    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // bus master; bready and rready stay high throughout
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] e);
        bq.push_back(e);
        req.awaddr  <= a;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= s;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        do @(posedge aclk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (!rsp.rvalid);
    endtask : rd

    function automatic int mult(input logic s, input logic h, input logic w);
        if (s || (h && w)) return 4;
        if (h || w) return 16;
        return 64;
    endfunction : mult

    // ==========================================================
    // monitor: cyc counts edges since the last tick, or one more than edges since the write edge
    always @(posedge aclk) begin
        if (aresetn && rsp.rvalid) begin
            total_checks++;
            if ({rsp.rresp, rsp.rdata} !== rq.pop_front()) err("read");
        end
        if (aresetn && rsp.bvalid) begin
            total_checks++;
            if (rsp.bresp !== bq.pop_front()) err("write response");
        end
        if (tick === 1'b1 && tq.size() > 0) begin
            total_checks++;
            if (cyc != tq[0]) err("tick spacing");
            void'(tq.pop_front());
        end
        cyc = (rsp.bvalid && !bv_q) ? 2 : ((tick === 1'b1) ? 1 : cyc + 1);
        bv_q = rsp.bvalid;
    end

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        repeat (60000) @(posedge aclk);
        err("timeout");
        final_report();
    end

    initial begin : main
        logic [7:0] lo;
        int         p;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        aresetn = 1'b0;
        bv_q = 1'b0;
        idle_in = 1'($random(seed));
        ovf_in = 1'($random(seed));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, {26'h0, ovf_in, idle_in, 6'h00});
        for (int a = 4; a <= 16; a += 4) rd(8'(a), 34'h0);
        rd(8'h14, {2'h2, 32'h0});
        wr(8'h14, 8'hff, 4'hf, 2'h2);
        wr(8'h00, 8'hff, 4'hf, 2'h0);
        wr(8'h00, 8'h00, 4'h0, 2'h0);
        rd(8'h00, {26'h0, ovf_in, idle_in, 6'h1b});
        total_checks++;
        if (lvl_o !== 3'b111) err("control levels");
        // high divisor byte is 1 in every mode: only wide mode may see it
        for (int m = 0; m < 8; m++) begin
            lo = 8'($random(seed) & 7);
            wr(8'h0c, {6'h0, m[1:0]}, 4'hf, 2'h0);
            wr(8'h00, {4'h0, m[2], 3'h0}, 4'hf, 2'h0);
            wr(8'h08, 8'h01, 4'hf, 2'h0);
            wr(8'h04, lo, 4'hf, 2'h0);
            p = mult(m[0], m[1], m[2]) * ((m[2] ? 256 : 0) + lo + 1);
            // first check expects one more: cyc restarts at 2, not 1, after the write edge
            tq.push_back(p + 1);
            tq.push_back(p);
            while (tq.size() > 0) @(posedge aclk);
            total_checks++;
            if (sync_o !== m[0]) err("sync level");
        end
        final_report();
    end
endmodule : tb_serial_baud_rate_generator

//--- shared/baud_pkg.sv
package baud_pkg;

    // ================================================================
    // axi4-lite carriers
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    // ================================================================
    // register selection
    typedef enum {
        SEL_CONTROL,
        SEL_DIV_LOW,
        SEL_DIV_HIGH,
        SEL_MODE,
        SEL_COUNT,
        SEL_NONE
    } reg_sel_t;

endpackage : baud_pkg

//--- shared/baud_regs.svh
`ifndef BAUD_REGS_SVH
`define BAUD_REGS_SVH

// ====================================================================
// register byte offsets
`define OFS_BAUD_CONTROL   8'h00
`define OFS_DIVISOR_LOW    8'h04
`define OFS_DIVISOR_HIGH   8'h08
`define OFS_MODE_CONTROL   8'h0c
`define OFS_TIMER_COUNT    8'h10

// ====================================================================
// baud_control fields
`define BC_AUTOBAUD_OVF    7
`define BC_RX_IDLE         6
`define BC_CLK_POLARITY    4
`define BC_WIDE_DIVIDER    3
`define BC_WAKEUP_EN       1
`define BC_AUTOBAUD_EN     0
`define BC_RW_MASK         8'h1b

// ====================================================================
// mode_control fields
`define MC_SYNC_SELECT     0
`define MC_HIGH_SPEED      1
`define MC_RW_MASK         8'h03

// ====================================================================
// reset values
`define RST_BAUD_CONTROL   8'h00
`define RST_DIVISOR        8'h00
`define RST_MODE_CONTROL   8'h00

// ====================================================================
// per-bit multipliers, stored as last prescaler count (multiplier - 1)
`define PRESC_LAST_64      6'h3f
`define PRESC_LAST_16      6'h0f
`define PRESC_LAST_4       6'h03

// ====================================================================
// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif
